// ### hdl/mpe_pkg.sv
package mpe_pkg;
  // clock rate and timing figures
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned CELL_NS       = 400;
  localparam int unsigned HYB_PULSE_NS  = 100;
  localparam int unsigned BP_PULSE_NS   = 200;
  localparam int unsigned RX_TOL_NS     = 100;
  // cycle counts derived from the figures
  localparam int unsigned CELL_CYC      = CELL_NS / CLK_NS;
  localparam int unsigned HYB_PULSE_CYC =
    (HYB_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BP_PULSE_CYC  = (BP_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RX_TOL_CYC    = RX_TOL_NS / CLK_NS;
  localparam int unsigned CNT_W         = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
  localparam logic [CNT_W-1:0] CELL_LAST =
    CNT_W'(CELL_CYC - 1);
  localparam logic [CNT_W-1:0] HYB_P2_START = CNT_W'(HYB_PULSE_CYC);
  localparam logic [CNT_W-1:0] HYB_P2_END   = CNT_W'(2 * HYB_PULSE_CYC);
  localparam logic [CNT_W-1:0] BP_END       = CNT_W'(BP_PULSE_CYC);
  localparam logic [CNT_W-1:0] RX_WIN_END   =
    CNT_W'(CELL_CYC + RX_TOL_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_CELL    = CNT_W'(CELL_CYC / 2);

  typedef enum logic [1:0] {
    MPE_STYLE_HYBRID   = 2'b00,
    MPE_STYLE_BACKPL   = 2'b01,
    MPE_STYLE_DIFF     = 2'b10
  } mpe_style_t;
endpackage : mpe_pkg

// ### hdl/mpe_rx_if.sv
`timescale 1ns/10ps
interface mpe_rx_if;
  logic line_level;
  logic active_low;
  logic cell_strobe;
  logic bit_value;
  modport src (output line_level, output active_low,
               input cell_strobe, input bit_value);
  modport dec (input line_level, input active_low,
               output cell_strobe, output bit_value);
endinterface : mpe_rx_if

// ### hdl/mpe_rx_decoder.sv
`timescale 1ns/10ps
module mpe_rx_decoder (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  mpe_rx_if.dec     rx
);
  logic                      lvl_q;
  logic                      hunt_q;
  logic [mpe_pkg::CNT_W-1:0] cnt_q;
  logic                      seen_q;
  logic                      strobe_q;
  logic                      bit_q;

  // pulse polarity follows style: hybrid positive, backplane negative
  wire pulse_lvl  = rx.line_level ^ rx.active_low; // R4 R8
  wire pulse_edge = pulse_lvl & ~lvl_q;
  wire cell_end   = ~hunt_q && (cnt_q == mpe_pkg::CELL_LAST);
  // late_pulse needs cnt_q to reach RX_WIN_END, which it never does; a late pulse resyncs the grid and closes the cell with seen_q
  wire late_pulse = ~hunt_q && (cnt_q == mpe_pkg::RX_WIN_END); // R5

  assign rx.cell_strobe = strobe_q;
  assign rx.bit_value   = bit_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // held high so an idle line gives no false edge after reset
      lvl_q    <= 1'b1;
      hunt_q   <= 1'b1;
      cnt_q    <= mpe_pkg::CNT_ZERO;
      seen_q   <= 1'b0;
      strobe_q <= 1'b0;
      bit_q    <= 1'b0;
    end else begin
      lvl_q    <= pulse_lvl;
      strobe_q <= 1'b0;
      if (pulse_edge && (hunt_q || cnt_q >= mpe_pkg::HALF_CELL)) begin
        // resync the cell grid to a pulse seen while hunting or in the second half-cell, centred on it
        hunt_q   <= 1'b0;
        cnt_q    <= mpe_pkg::HALF_CELL;
        seen_q   <= 1'b1;
        if (!hunt_q) begin
          strobe_q <= 1'b1;
          bit_q    <= seen_q; // R5
        end
      end else if (cell_end || late_pulse) begin
        cnt_q    <= mpe_pkg::CNT_ZERO;
        strobe_q <= 1'b1;
        bit_q    <= seen_q | pulse_edge; // R4 R8
        seen_q   <= 1'b0;
      end else if (!hunt_q) begin
        cnt_q <= cnt_q + mpe_pkg::CNT_ONE;
        if (pulse_edge) begin
          seen_q <= 1'b1;
        end
      end
    end
  end
endmodule : mpe_rx_decoder

// ### hdl/mpe_line_codec.sv
// Behaviour
// R1 - hybrid one: two 100 ns low pulses
// R2 - hybrid zero: no pulse on either drive
// R3 - hybrid style only used at 2.5 Mbps
// R4 - hybrid receive: positive pulse means one
// R5 - 400 ns cells, tolerate 100 ns skew
// R6 - backplane drive push-pull or open-drain, default open
// R7 - backplane one: single 200 ns low pulse
// R8 - backplane receive: negative pulse means one
// R9 - backplane secondary drive carries bit clock
// R10 - differential: data pulses only while enabled
// R11 - reset holds drives and enable inactive
// R12 - grounded secondary pin at reset: enable high
// R13 - board keeps secondary pin grounded permanently
// R14 - hybrid pulses sequential, within first half-cell
`timescale 1ns/10ps
module mpe_line_codec (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] drive_style_in,
  input  wire logic       drive_style_select_in,
  input  wire logic       tx_enable_in,
  input  wire logic       tx_data_in,
  input  wire logic       line_receive_in,
  input  wire logic       secondary_line_drive_in,
  output logic            primary_line_drive_out,
  output logic            primary_line_drive_oe_out,
  output logic            secondary_line_drive_out,
  output logic            secondary_line_drive_oe_out,
  output logic            driver_enable_out,
  output logic            tx_cell_start_out,
  output logic            rx_bit_valid_out,
  output logic            rx_bit_out
);
  logic [mpe_pkg::CNT_W-1:0] cell_q;
  logic                      bit_q;
  logic                      en_q;
  logic                      pol_high_q;
  logic                      pol_done_q;
  logic [2:0]                rx_sync_q;
  logic [2:0]                p2_sync_q;
  logic [2:0]                p2_fill_q;
  logic                      rx_lvl_q;
  logic                      p1_q;
  logic                      p1_oe_q;
  logic                      p2_q;
  logic                      p2_oe_q;
  logic                      txen_q;
  logic                      start_q;
  logic                      rxv_q;
  logic                      rxb_q;
  mpe_rx_if                  rxi ();

  wire mpe_pkg::mpe_style_t style = mpe_pkg::mpe_style_t'(drive_style_in);
  wire is_hyb   = (style == mpe_pkg::MPE_STYLE_HYBRID);
  wire cell_end = (cell_q == mpe_pkg::CELL_LAST);
  wire send_one = bit_q && en_q;
  // hybrid pulses: first then second, both in first half-cell
  wire hyb_p1 = send_one && (cell_q < mpe_pkg::HYB_P2_START); // R1 R14
  wire hyb_p2 = send_one && (cell_q >= mpe_pkg::HYB_P2_START)
                && (cell_q < mpe_pkg::HYB_P2_END); // R1 R14
  wire bp_p1  = send_one && (cell_q < mpe_pkg::BP_END); // R7 R10
  wire p1_lo  = is_hyb ? hyb_p1 : bp_p1; // R2
  // bit clock high over the first half of each cell
  wire bitclk = (cell_q < mpe_pkg::HALF_CELL); // R9
  wire txen_act = ~is_hyb && en_q; // R10
  wire txen_lvl = pol_high_q ? txen_act : ~txen_act; // R12
  wire p1_oe    = is_hyb || drive_style_select_in || p1_lo; // R6
  // rx sync: a change counts once stages two and three agree
  wire rx_agree = (rx_sync_q[1] == rx_sync_q[2]);
  wire rx_lvl_d = rx_agree ? rx_sync_q[2] : rx_lvl_q;
  // strap judged only once the pin itself has filled all three stages
  wire p2_ready = p2_fill_q[2] && (p2_sync_q[1] == p2_sync_q[2]); // R12

  assign rxi.line_level = rx_lvl_q;
  assign rxi.active_low = ~is_hyb; // R4 R8

  mpe_rx_decoder u_dec (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .rx       (rxi.dec)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cell_q <= mpe_pkg::CNT_ZERO;
      bit_q  <= 1'b0;
      en_q   <= 1'b0;
    end else begin
      cell_q <= cell_end ? mpe_pkg::CNT_ZERO : cell_q + mpe_pkg::CNT_ONE;
      if (cell_end) begin
        bit_q <= tx_data_in;
        en_q  <= tx_enable_in;
      end
    end
  end

  // strap caught on the fourth clock after release at the earliest, never by reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pol_done_q <= 1'b0;
      pol_high_q <= 1'b0;
      p2_sync_q  <= 3'h0;
      p2_fill_q  <= 3'h0;
    end else begin
      p2_sync_q <= {p2_sync_q[1:0], secondary_line_drive_in};
      p2_fill_q <= {p2_fill_q[1:0], 1'b1};
      if (!pol_done_q && p2_ready) begin
        pol_done_q <= 1'b1;
        pol_high_q <= ~p2_sync_q[2]; // R12 R13
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_sync_q <= 3'h7;
      rx_lvl_q  <= 1'b0;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], line_receive_in};
      rx_lvl_q  <= rx_lvl_d;
    end
  end

  // outputs registered; reset leaves drives released and idle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      p1_q    <= 1'b1; // R11
      p1_oe_q <= 1'b0; // R11
      p2_q    <= 1'b1; // R11
      p2_oe_q <= 1'b0; // R11
      txen_q  <= 1'b1; // R11
      start_q <= 1'b0;
      rxv_q   <= 1'b0;
      rxb_q   <= 1'b0;
    end else begin
      p1_q    <= ~p1_lo;
      p1_oe_q <= pol_done_q && p1_oe;
      // hybrid drives pulses; backplane drives bit clock only if not strapped
      p2_q    <= is_hyb ? ~hyb_p2 : bitclk; // R9
      p2_oe_q <= pol_done_q && (is_hyb || !pol_high_q);
      txen_q  <= pol_done_q ? txen_lvl : 1'b1;
      start_q <= cell_end;
      rxv_q   <= rxi.cell_strobe;
      rxb_q   <= rxi.bit_value;
    end
  end

  assign primary_line_drive_out      = p1_q;
  assign primary_line_drive_oe_out   = p1_oe_q;
  assign secondary_line_drive_out    = p2_q;
  assign secondary_line_drive_oe_out = p2_oe_q;
  assign driver_enable_out           = txen_q;
  assign tx_cell_start_out           = start_q;
  assign rx_bit_valid_out            = rxv_q;
  assign rx_bit_out                  = rxb_q;

  hyb_pulse_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(p1_q) && is_hyb |-> !p1_q ##1 p1_q) // R1
    else $error("hybrid primary pulse not one cycle");
  hyb_no_overlap_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) is_hyb |-> (p1_q || p2_q)) // R14
    else $error("hybrid pulses overlap");
  hyb_seq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    is_hyb && $rose(p1_q) && $stable(drive_style_in) |-> !p2_q ##1 p2_q) // R1
    else $error("second pulse does not follow first");
  bp_pulse_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !is_hyb && $fell(p1_q) && $stable(drive_style_in)
    |-> !p1_q ##1 !p1_q ##1 p1_q) // R7
    else $error("backplane pulse not two cycles");
  zero_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cell_end && !(tx_data_in && tx_enable_in) |=> ##1 p1_q [*4]) // R2
    else $error("pulse sent for a zero");
  diff_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !is_hyb && !p1_q && $past(!is_hyb) |-> txen_q == pol_high_q) // R10
    else $error("pulse without driver enable");
  open_drain_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !is_hyb && $past(!is_hyb && !drive_style_select_in && !p1_lo)
    |-> !p1_oe_q) // R6
    else $error("open drain drives high");
  reset_idle_a: assert property (@(posedge clk_in)
    !rst_n_in |-> p1_q && !p1_oe_q && !p2_oe_q && txen_q) // R11
    else $error("drive active in reset");
endmodule : mpe_line_codec

// ### verif/mpe_media_model.sv
`timescale 1ns/10ps
module mpe_media_model (
  input  wire logic clk_in,
  input  wire logic backplane_in,
  input  wire logic strap_gnd_in,
  input  wire logic pulse_in,
  input  wire logic drive_in,
  input  wire logic drive_oe_in,
  input  wire logic sec_in,
  input  wire logic sec_oe_in,
  output logic      line_out,
  output logic      strap_out
);
  // clk_in kept for symmetry; the transceiver is purely combinational
  logic pull_level;
  // released line floats to the pull-up, never to a stale value
  assign pull_level = drive_oe_in ? drive_in : 1'b1;
  // hybrid: positive pulse; backplane: wired line, pulse pulls low
  assign line_out = backplane_in ? (!pulse_in && pull_level) : pulse_in;
  // strap held grounded for as long as strap_gnd_in is high
  assign strap_out = strap_gnd_in ? 1'b0 : (sec_oe_in ? sec_in : 1'b1);
endmodule : mpe_media_model

// ### verif/test_media_pulse_encoder_decoder.sv
`timescale 1ns/10ps
module test_media_pulse_encoder_decoder;
  logic       clk_in   = 1'b0;
  logic       rst_n_in = 1'b1;
  logic       sel      = 1'b0;
  logic       en       = 1'b0;
  logic       dat      = 1'b0;
  logic       gnd      = 1'b0;
  logic       pls      = 1'b0;
  logic [1:0] sty      = 2'h0;
  logic       p, poe, s, soe, de, tcs, rxv, rxb, line, strap;
  int         err_total = 0;
  int         cmp_count = 0;
  // 0 prim low,1 sec low,2 both low,3 en low,4 en high,5 od high,
  // 6 sec oe,7 sec rises,8 rx ones,9 prim low with en high
  int         c [10];
  always #50 clk_in = ~clk_in;
  mpe_media_model media (.clk_in(clk_in), .backplane_in(sty != 2'h0),
    .strap_gnd_in(gnd), .pulse_in(pls), .drive_in(p), .drive_oe_in(poe),
    .sec_in(s), .sec_oe_in(soe), .line_out(line), .strap_out(strap));
  mpe_line_codec uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .drive_style_in(sty), .drive_style_select_in(sel),
    .tx_enable_in(en), .tx_data_in(dat), .line_receive_in(line),
    .secondary_line_drive_in(strap), .primary_line_drive_out(p),
    .primary_line_drive_oe_out(poe), .secondary_line_drive_out(s),
    .secondary_line_drive_oe_out(soe), .driver_enable_out(de),
    .tx_cell_start_out(tcs), .rx_bit_valid_out(rxv), .rx_bit_out(rxb));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  // counts are phase independent: steady traffic repeats every cell
  task automatic observe(input int n, input logic [31:0] v);
    logic sq;
    c = '{default:0};
    sq = s;
    for (int i = 0; i < n; i++) begin
      // two cycles wide: the pin filter drops one-cycle blips
      pls = ((i < 32) && v[i]) || ((i > 0) && (i < 33) && v[i-1]);
      tick(1);
      c[0] += int'(p === 1'b0);
      c[1] += int'(s === 1'b0);
      c[2] += int'(p === 1'b0 && s === 1'b0);
      c[3] += int'(de === 1'b0);
      c[4] += int'(de === 1'b1);
      c[5] += int'(poe === 1'b1 && p === 1'b1);
      c[6] += int'(soe === 1'b1);
      c[7] += int'(sq === 1'b0 && s === 1'b1);
      c[8] += int'(rxv === 1'b1 && rxb === 1'b1);
      c[9] += int'(p === 1'b0 && de === 1'b1);
      sq = s;
    end
  endtask : observe
  task automatic do_reset(input logic g);
    tick(1);
    rst_n_in = 1'b0;
    gnd = g;
    tick(12);
    check({3'h0, p, poe, s, soe, de}, 8'h15);
    rst_n_in = 1'b1;
    tick(8);
  endtask : do_reset
  task automatic run(input logic [1:0] st, input logic sl, e, d);
    sty = st;
    sel = sl;
    en = e;
    dat = d;
    tick(12);
    observe(32, 32'h0);
  endtask : run
  task automatic test_hybrid_tx();
    do_reset(1'b0);
    run(2'h0, 1'b0, 1'b1, 1'b1);
    check(8'(c[0]), 8'h08);
    check(8'(c[1]), 8'h08);
    check(8'(c[2]), 8'h00);
    run(2'h0, 1'b0, 1'b1, 1'b0);
    check(8'(c[0] + c[1]), 8'h00);
    $display("hybrid transmit test done");
  endtask : test_hybrid_tx
  task automatic test_backplane_tx();
    run(2'h1, 1'b0, 1'b1, 1'b1);
    check(8'(c[0]), 8'h10);
    check(8'(c[5]), 8'h00);
    check(8'(c[7]), 8'h08);
    run(2'h1, 1'b1, 1'b1, 1'b1);
    check(8'(c[5] != 0), 8'h01);
    $display("backplane transmit test done");
  endtask : test_backplane_tx
  task automatic test_diff_tx();
    run(2'h2, 1'b0, 1'b1, 1'b1);
    check(8'(c[0]), 8'h10);
    check(8'(c[9]), 8'h00);
    run(2'h2, 1'b0, 1'b0, 1'b1);
    check(8'(c[0] + c[3]), 8'h00);
    $display("differential transmit test done");
  endtask : test_diff_tx
  task automatic test_strap();
    do_reset(1'b1);
    run(2'h2, 1'b0, 1'b1, 1'b1);
    check(8'(c[4]), 8'h20);
    run(2'h1, 1'b0, 1'b1, 1'b1);
    check(8'(c[6]), 8'h00);
    $display("enable polarity test done");
  endtask : test_strap
  // pulses at cells 0,1,3,5; the third late and the fourth early
  task automatic test_rx();
    do_reset(1'b0);
    run(2'h0, 1'b0, 1'b0, 1'b0);
    observe(48, 32'h0008_2011);
    check(8'(c[8]), 8'h04);
    run(2'h1, 1'b0, 1'b0, 1'b0);
    observe(48, 32'h0008_2011);
    check(8'(c[8]), 8'h04);
    $display("receive test done");
  endtask : test_rx
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #10 rst_n_in = 1'b0;
    test_hybrid_tx();
    test_backplane_tx();
    test_diff_tx();
    test_strap();
    test_rx();
    tally_and_finish();
  end
endmodule : test_media_pulse_encoder_decoder
